// ---- dv/chan_event_src.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tirq_cfg.svh"

// Timer input channels: a request from the bench is registered onto the event output one cycle later
module chan_event_src (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire tirq_pkg::chan_vec_t fire_req,
	output var  tirq_pkg::chan_vec_t event_out
);
	import tirq_pkg::*;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			event_out <= `CHAN_ZERO;
		end else begin
			event_out <= fire_req;
		end
	end
endmodule : chan_event_src

`default_nettype wire

// ---- dv/timer_input_irq_status_mask_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tirq_cfg.svh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("Error at %0t: value %h expected %h", $time, (g), (e)); end end

module timer_input_irq_status_mask_tb;
	import tirq_pkg::*;

	logic       clk;
	logic       resetn;
	bus_addr_t  addr;
	data_byte_t wdata;
	logic       wr;
	logic       rd;
	data_byte_t rdata;
	chan_vec_t  fire_req;
	chan_vec_t  chan_event;
	group_vec_t group_req;
	logic       irq;
	int         fails;
	int         checked;

	chan_event_src src (
		.clk       (clk),
		.resetn    (resetn),
		.fire_req  (fire_req),
		.event_out (chan_event)
	);

	timer_input_irq_status_mask dut (
		.clk                       (clk),
		.resetn                    (resetn),
		.addr                      (addr),
		.wdata                     (wdata),
		.wr                        (wr),
		.rd                        (rd),
		.rdata                     (rdata),
		.timer_input_channel_event (chan_event),
		.group_req                 (group_req),
		.irq                       (irq)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	task automatic wr_reg(input bus_addr_t a, input data_byte_t d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input bus_addr_t a, input data_byte_t e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask : rd_chk

	task automatic fire(input chan_vec_t v);
		@(posedge clk);
		fire_req <= v;
		@(posedge clk);
		fire_req <= `CHAN_ZERO;
		repeat (2) @(posedge clk);
		#1;
	endtask : fire

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic t_reset;
		for (int i = 0; i < 11; i++) begin
			rd_chk(`ADDR_CTL_CH0_2 + i, 8'h00);
		end
		`CHK(group_req, 4'h0)
		`CHK(irq, 1'b0)
		$display("Done: reset values");
	endtask : t_reset

	task automatic t_layout;
		fire(20'hF_FFFF);
		`CHK(group_req, 4'hF)
		rd_chk(`ADDR_CTL_CH0_2, 8'h70);
		rd_chk(`ADDR_CTL_CH3_6, 8'hF0);
		rd_chk(`ADDR_FLAGS_CH7_11, 8'h1F);
		rd_chk(`ADDR_MASKS_CH7_11, 8'h00);
		rd_chk(`ADDR_FLAGS_CH12_19, 8'hFF);
		rd_chk(`ADDR_MASKS_CH12_19, 8'h00);
		$display("Done: flag layout");
	endtask : t_layout

	task automatic t_flag_clear;
		wr_reg(`ADDR_CTL_CH0_2, 8'hB8);
		rd_chk(`ADDR_CTL_CH0_2, 8'h30);
		wr_reg(`ADDR_FLAGS_CH12_19, 8'hFF);
		rd_chk(`ADDR_FLAGS_CH12_19, 8'hFF);
		wr_reg(`ADDR_FLAGS_CH12_19, 8'h5A);
		rd_chk(`ADDR_FLAGS_CH12_19, 8'h5A);
		$display("Done: flag clear");
	endtask : t_flag_clear

	task automatic t_masks;
		wr_reg(`ADDR_CTL_CH0_2, 8'hFF);
		rd_chk(`ADDR_CTL_CH0_2, 8'h37);
		wr_reg(`ADDR_MASKS_CH7_11, 8'hFF);
		rd_chk(`ADDR_MASKS_CH7_11, 8'h1F);
		rd_chk(`ADDR_FLAGS_CH7_11, 8'h1F);
		wr_reg(`ADDR_MASKS_CH12_19, 8'hFF);
		rd_chk(`ADDR_MASKS_CH12_19, 8'hFF);
		settle();
		`CHK(group_req, 4'h2)
		wr_reg(`ADDR_MASKS_CH7_11, 8'h00);
		wr_reg(`ADDR_MASKS_CH12_19, 8'h00);
		wr_reg(`ADDR_CTL_CH0_2, 8'h30);
		settle();
		`CHK(group_req, 4'hF)
		$display("Done: masks");
	endtask : t_masks

	task automatic t_race;
		@(posedge clk);
		fire_req <= 20'h0_0080;
		@(posedge clk);
		fire_req <= `CHAN_ZERO;
		addr     <= `ADDR_FLAGS_CH7_11;
		wdata    <= 8'h00;
		wr       <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd_chk(`ADDR_FLAGS_CH7_11, 8'h01);
		$display("Done: event against clear");
	endtask : t_race

	task automatic t_irq;
		rd_chk(`ADDR_EVT_STATUS, 8'h0F);
		wr_reg(`ADDR_EVT_STATUS, 8'h00);
		rd_chk(`ADDR_EVT_STATUS, 8'h0F);
		rd_chk(32'h0080_0250, 8'h00);
		`CHK(irq, 1'b0)
		wr_reg(`ADDR_EVT_ENABLE, 8'h01);
		rd_chk(`ADDR_EVT_ENABLE, 8'h01);
		`CHK(irq, 1'b1)
		wr_reg(`ADDR_EVT_CLEAR, 8'h01);
		settle();
		`CHK(irq, 1'b0)
		rd_chk(`ADDR_EVT_STATUS, 8'h0E);
		rd_chk(`ADDR_EVT_CLEAR, 8'h00);
		wr_reg(`ADDR_EVT_ENABLE, 8'h02);
		settle();
		`CHK(irq, 1'b1)
		wr_reg(`ADDR_EVT_ENABLE, 8'h00);
		settle();
		`CHK(irq, 1'b0)
		$display("Done: interrupt");
	endtask : t_irq

	task automatic t_midreset;
		wr_reg(`ADDR_MASKS_CH12_19, 8'hA5);
		fire(20'hF_FFFF);
		wr_reg(`ADDR_EVT_ENABLE, 8'h0F);
		settle();
		`CHK(group_req, 4'hF)
		`CHK(irq, 1'b1)
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1;
		`CHK(group_req, 4'h0)
		`CHK(irq, 1'b0)
		for (int i = 0; i < 11; i++) begin
			rd_chk(`ADDR_CTL_CH0_2 + i, 8'h00);
		end
		$display("Done: reset in mid-run");
	endtask : t_midreset

	initial begin
		#1_000_000;
		fails++;
		give_verdict();
	end

	initial begin
		resetn   = 1'b0;
		addr     = `ADDR_CTL_CH0_2;
		wdata    = `BYTE_ZERO;
		wr       = 1'b0;
		rd       = 1'b0;
		fire_req = `CHAN_ZERO;
		fails    = 0;
		checked  = 0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_layout();
		t_flag_clear();
		t_masks();
		t_race();
		t_irq();
		t_midreset();
		give_verdict();
	end
endmodule : timer_input_irq_status_mask_tb

`default_nettype wire

// ---- rtl/flag_mask_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tirq_cfg.svh"

module flag_mask_bank (
	input  wire logic        clk,
	input  wire logic        resetn,
	chan_irq_if.bank         bus
);
	import tirq_pkg::*;

	chan_vec_t flags_r;
	chan_vec_t flags_nxt;
	chan_vec_t masks_r;
	chan_vec_t masks_nxt;

	// Channel event wins over a clear in the same cycle
	assign flags_nxt = (flags_r & ~bus.flag_clr) | bus.event_vec;
	assign masks_nxt = (masks_r & ~bus.mask_we) | (bus.mask_wd & bus.mask_we);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flags_r <= `CHAN_ZERO;
			masks_r <= `CHAN_ZERO;
		end else begin
			flags_r <= flags_nxt;
			masks_r <= masks_nxt;
		end
	end

	assign bus.flags = flags_r;
	assign bus.masks = masks_r;
endmodule : flag_mask_bank

`default_nettype wire

// ---- rtl/group_event_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tirq_cfg.svh"

module group_event_unit (
	input  wire logic        clk,
	input  wire logic        resetn,
	chan_irq_if.evt          bus
);
	import tirq_pkg::*;

	group_vec_t stat_r;
	group_vec_t stat_nxt;
	group_vec_t en_r;
	group_vec_t en_nxt;
	group_vec_t clr_vec;
	logic       irq_r;

	// Write one to clear; a new event in the same cycle keeps the bit set
	assign clr_vec  = bus.evt_clr_we ? bus.evt_wd : `GROUP_ZERO;
	assign stat_nxt = (stat_r & ~clr_vec) | bus.grp_evt;
	assign en_nxt   = bus.evt_en_we ? bus.evt_wd : en_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			stat_r <= `GROUP_ZERO;
			en_r   <= `GROUP_ZERO;
			irq_r  <= `BIT_ZERO;
		end else begin
			stat_r <= stat_nxt;
			en_r   <= en_nxt;
			irq_r  <= |(stat_nxt & en_nxt);
		end
	end

	assign bus.evt_stat = stat_r;
	assign bus.evt_en   = en_r;
	assign bus.irq_lvl  = irq_r;
endmodule : group_event_unit

`default_nettype wire

// ---- rtl/timer_input_irq_status_mask.sv ----
// Summary of operation
// - A flag reads 1 while its channel request is pending, else 0.
// - Writing 0 to a flag clears it; writing 1 leaves it unchanged.
// - Mask 0 forwards the request, mask 1 blocks it; masks read and write freely.
// - Unassigned bits read 0 and ignore writes.
// - First register: flags of channels 2..0 and their masks.
// - Second register: flags of channels 6..3 and their masks.
// - Third register: flags of channels 11..7 only.
// - Fourth register: masks of channels 11..7 only.
// - Fifth register: flags of channels 19..12 only.
// - Sixth register: masks of channels 19..12 only.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tirq_cfg.svh"

module timer_input_irq_status_mask (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire tirq_pkg::bus_addr_t  addr,
	input  wire tirq_pkg::data_byte_t wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output var  tirq_pkg::data_byte_t rdata,
	input  wire tirq_pkg::chan_vec_t  timer_input_channel_event,
	output var  tirq_pkg::group_vec_t group_req,
	output var  logic                 irq
);
	import tirq_pkg::*;

	function automatic logic addr_hit(input bus_addr_t a, input bus_addr_t ofs);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	function automatic group_vec_t group_reduce(input chan_vec_t v);
		group_reduce = {|v[`CH_G3], |v[`CH_G2], |v[`CH_G1], |v[`CH_G0]};
	endfunction : group_reduce

	chan_irq_if ch_if ();

	data_byte_t rdata_r;
	group_vec_t group_req_r;

	logic       hit0;
	logic       hit1;
	logic       hit2;
	logic       hit3;
	logic       hit4;
	logic       hit5;
	logic       hit_stat;
	logic       hit_clr;
	logic       hit_en;
	logic       wr0;
	logic       wr1;
	logic       wr2;
	logic       wr3;
	logic       wr4;
	logic       wr5;
	chan_vec_t  flags;
	chan_vec_t  masks;
	chan_vec_t  pending;
	group_vec_t group_now;
	data_byte_t byte_r0;
	data_byte_t byte_r1;
	data_byte_t byte_r2;
	data_byte_t byte_r3;
	data_byte_t byte_r4;
	data_byte_t byte_r5;
	data_byte_t byte_stat;
	data_byte_t byte_en;
	data_byte_t rd_byte;

	// Address decode
	assign hit0     = addr_hit(addr, `ADDR_CTL_CH0_2);
	assign hit1     = addr_hit(addr, `ADDR_CTL_CH3_6);
	assign hit2     = addr_hit(addr, `ADDR_FLAGS_CH7_11);
	assign hit3     = addr_hit(addr, `ADDR_MASKS_CH7_11);
	assign hit4     = addr_hit(addr, `ADDR_FLAGS_CH12_19);
	assign hit5     = addr_hit(addr, `ADDR_MASKS_CH12_19);
	assign hit_stat = addr_hit(addr, `ADDR_EVT_STATUS);
	assign hit_clr  = addr_hit(addr, `ADDR_EVT_CLEAR);
	assign hit_en   = addr_hit(addr, `ADDR_EVT_ENABLE);

	assign wr0 = wr & hit0;
	assign wr1 = wr & hit1;
	assign wr2 = wr & hit2;
	assign wr3 = wr & hit3;
	assign wr4 = wr & hit4;
	assign wr5 = wr & hit5;

	// Flag clears: a zero written to an assigned flag bit clears that flag
	assign ch_if.flag_clr = {
		{`G3_W{wr4}} & ~wdata[`R4_FLAG],
		{`G2_W{wr2}} & ~wdata[`R2_FLAG],
		{`G1_W{wr1}} & ~wdata[`R1_FLAG],
		{`G0_W{wr0}} & ~wdata[`R0_FLAG]
	};

	// Mask writes: only assigned mask bits are stored
	assign ch_if.mask_we = {
		{`G3_W{wr5}},
		{`G2_W{wr3}},
		{`G1_W{wr1}},
		{`G0_W{wr0}}
	};
	assign ch_if.mask_wd = {wdata[`R5_MASK], wdata[`R3_MASK], wdata[`R1_MASK], wdata[`R0_MASK]};

	assign ch_if.event_vec = timer_input_channel_event;

	flag_mask_bank u_bank (
		.clk    (clk),
		.resetn (resetn),
		.bus    (ch_if.bank)
	);

	assign flags = ch_if.flags;
	assign masks = ch_if.masks;

	// Group requests: any set flag with its mask clear
	assign pending   = flags & ~masks;
	assign group_now = group_reduce(pending);

	// Rising group requests feed the sticky event status
	assign ch_if.grp_evt    = group_now & ~group_req_r;
	assign ch_if.evt_wd     = wdata[`EVT_FIELD];
	assign ch_if.evt_clr_we = wr & hit_clr;
	assign ch_if.evt_en_we  = wr & hit_en;

	group_event_unit u_evt (
		.clk    (clk),
		.resetn (resetn),
		.bus    (ch_if.evt)
	);

	// Read data, unassigned bits forced to zero
	assign byte_r0   = {`BIT_ZERO, flags[`CH_G0], `BIT_ZERO, masks[`CH_G0]};
	assign byte_r1   = {flags[`CH_G1], masks[`CH_G1]};
	assign byte_r2   = {3'h0, flags[`CH_G2]};
	assign byte_r3   = {3'h0, masks[`CH_G2]};
	assign byte_r4   = flags[`CH_G3];
	assign byte_r5   = masks[`CH_G3];
	assign byte_stat = {4'h0, ch_if.evt_stat};
	assign byte_en   = {4'h0, ch_if.evt_en};

	assign rd_byte = hit0     ? byte_r0   :
	                 hit1     ? byte_r1   :
	                 hit2     ? byte_r2   :
	                 hit3     ? byte_r3   :
	                 hit4     ? byte_r4   :
	                 hit5     ? byte_r5   :
	                 hit_stat ? byte_stat :
	                 hit_en   ? byte_en   : `BYTE_ZERO;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_r     <= `BYTE_ZERO;
			group_req_r <= `GROUP_ZERO;
		end else begin
			rdata_r     <= rd ? rd_byte : `BYTE_ZERO;
			group_req_r <= group_now;
		end
	end

	assign rdata     = rdata_r;
	assign group_req = group_req_r;
	assign irq       = ch_if.irq_lvl;

	a_reset_clear: assert property (@(posedge clk)
		$rose(resetn) |-> (flags == `CHAN_ZERO) && (masks == `CHAN_ZERO)
		&& (group_req == `GROUP_ZERO) && !irq)
		else $error("State not cleared by reset");

	a_event_sets: assert property (@(posedge clk) disable iff (!resetn)
		|timer_input_channel_event |=>
		((flags & $past(timer_input_channel_event)) == $past(timer_input_channel_event)))
		else $error("Channel event did not set its flag");

	a_flag_holds: assert property (@(posedge clk) disable iff (!resetn)
		(!wr && timer_input_channel_event == `CHAN_ZERO) |=> flags == $past(flags))
		else $error("Flag changed without event or write");

	a_clear_zero: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit4 |=> flags[`CH_G3] ==
		(($past(flags[`CH_G3]) & $past(wdata)) | $past(timer_input_channel_event[`CH_G3])))
		else $error("Flag write of zero or one misbehaved");

	a_event_wins: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit2 && wdata[`R2_FLAG] == 5'h00 && timer_input_channel_event[7] |=> flags[7])
		else $error("Event lost to a simultaneous clear");

	a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit5 |=> masks[`CH_G3] == $past(wdata))
		else $error("Mask write not stored");

	a_group_gate: assert property (@(posedge clk) disable iff (!resetn)
		##1 group_req[3] == $past(|(flags[`CH_G3] & ~masks[`CH_G3])))
		else $error("Group request does not follow unmasked flags");

	a_reg0_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit0 |=> rdata ==
		{1'b0, $past(flags[`CH_G0]), 1'b0, $past(masks[`CH_G0])})
		else $error("First register read wrong");

	a_reg1_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit1 |=> rdata == {$past(flags[`CH_G1]), $past(masks[`CH_G1])})
		else $error("Second register read wrong");

	a_reg2_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit2 |=> rdata[7:5] == 3'h0 && rdata[4:0] == $past(flags[`CH_G2]))
		else $error("Third register read wrong");

	a_reg3_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit3 |=> rdata[7:5] == 3'h0 && rdata[4:0] == $past(masks[`CH_G2]))
		else $error("Fourth register read wrong");

	a_reg4_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit4 |=> rdata == $past(flags[`CH_G3]))
		else $error("Fifth register read wrong");

	a_unused_write: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit3 |=> masks[`CH_G3] == $past(masks[`CH_G3])
		&& flags[`CH_G2] == ($past(flags[`CH_G2]) | $past(timer_input_channel_event[`CH_G2])))
		else $error("Write reached unassigned or foreign bits");

	a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
		!rd |=> rdata == `BYTE_ZERO)
		else $error("Read data outside the read answer cycle");

	a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
		irq == |(ch_if.evt_stat & ch_if.evt_en))
		else $error("Interrupt level mismatch");

	a_reg5_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit5 |=> rdata == $past(masks[`CH_G3]))
		else $error("Sixth register read wrong");

	a_stat_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit_stat |=> rdata == {`GROUP_ZERO, $past(ch_if.evt_stat)})
		else $error("Event status read wrong");

	a_en_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && hit_en |=> rdata == {`GROUP_ZERO, $past(ch_if.evt_en)})
		else $error("Event enable read wrong");

	a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn)
		rd && !(hit0 || hit1 || hit2 || hit3 || hit4 || hit5 || hit_stat || hit_en)
		|=> rdata == `BYTE_ZERO)
		else $error("Unmapped read returned nonzero data");

	a_mask0_write: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit0 |=> masks[`CH_G0] == $past(wdata[`R0_MASK]))
		else $error("First register mask write not stored");

	a_mask1_write: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit1 |=> masks[`CH_G1] == $past(wdata[`R1_MASK]))
		else $error("Second register mask write not stored");

	a_mask3_write: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit3 |=> masks[`CH_G2] == $past(wdata[`R3_MASK]))
		else $error("Fourth register mask write not stored");

	a_clear0_zero: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit0 |=> flags[`CH_G0] == (($past(flags[`CH_G0]) & $past(wdata[`R0_FLAG]))
		| $past(timer_input_channel_event[`CH_G0])))
		else $error("First register flag write misbehaved");

	a_clear1_zero: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit1 |=> flags[`CH_G1] == (($past(flags[`CH_G1]) & $past(wdata[`R1_FLAG]))
		| $past(timer_input_channel_event[`CH_G1])))
		else $error("Second register flag write misbehaved");

	a_clear2_zero: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit2 |=> flags[`CH_G2] == (($past(flags[`CH_G2]) & $past(wdata[`R2_FLAG]))
		| $past(timer_input_channel_event[`CH_G2])))
		else $error("Third register flag write misbehaved");

	a_flag_addr_masks: assert property (@(posedge clk) disable iff (!resetn)
		wr && (hit2 || hit4) |=> masks == $past(masks))
		else $error("Flag-only write changed a mask");

	a_group_gate0: assert property (@(posedge clk) disable iff (!resetn)
		##1 group_req[0] == $past(|(flags[`CH_G0] & ~masks[`CH_G0])))
		else $error("Group 0 request does not follow unmasked flags");

	a_group_gate1: assert property (@(posedge clk) disable iff (!resetn)
		##1 group_req[1] == $past(|(flags[`CH_G1] & ~masks[`CH_G1])))
		else $error("Group 1 request does not follow unmasked flags");

	a_group_gate2: assert property (@(posedge clk) disable iff (!resetn)
		##1 group_req[2] == $past(|(flags[`CH_G2] & ~masks[`CH_G2])))
		else $error("Group 2 request does not follow unmasked flags");

	a_stat_rise: assert property (@(posedge clk) disable iff (!resetn)
		(ch_if.evt_stat & group_req & ~$past(group_req)) == (group_req & ~$past(group_req)))
		else $error("Rising group request did not set its status bit");

	a_evt_clear: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit_clr |=> (ch_if.evt_stat & $past(wdata[`EVT_FIELD]))
		== $past(ch_if.grp_evt & wdata[`EVT_FIELD]))
		else $error("Event clear did not clear its status bits");

	a_stat_readonly: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit_stat |=> ch_if.evt_stat == $past(ch_if.evt_stat | ch_if.grp_evt))
		else $error("Write reached the read-only event status");

	a_en_write: assert property (@(posedge clk) disable iff (!resetn)
		wr && hit_en |=> ch_if.evt_en == $past(wdata[`EVT_FIELD]))
		else $error("Event enable write not stored");
endmodule : timer_input_irq_status_mask

`default_nettype wire

// ---- shared/chan_irq_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface chan_irq_if;
	import tirq_pkg::*;
	chan_vec_t  event_vec;
	chan_vec_t  flag_clr;
	chan_vec_t  mask_we;
	chan_vec_t  mask_wd;
	chan_vec_t  flags;
	chan_vec_t  masks;
	group_vec_t grp_evt;
	group_vec_t evt_wd;
	logic       evt_clr_we;
	logic       evt_en_we;
	group_vec_t evt_stat;
	group_vec_t evt_en;
	logic       irq_lvl;

	modport ctl (
		output event_vec, flag_clr, mask_we, mask_wd, grp_evt, evt_wd, evt_clr_we,
		       evt_en_we,
		input  flags, masks, evt_stat, evt_en, irq_lvl
	);
	modport bank (
		input  event_vec, flag_clr, mask_we, mask_wd,
		output flags, masks
	);
	modport evt (
		input  grp_evt, evt_wd, evt_clr_we, evt_en_we,
		output evt_stat, evt_en, irq_lvl
	);
endinterface : chan_irq_if

`default_nettype wire

// ---- shared/tirq_cfg.svh ----
`ifndef TIRQ_CFG_SVH
`define TIRQ_CFG_SVH

// Widths
`define CHAN_CNT       20
`define GROUP_CNT      4
`define DATA_W         8
`define ADDR_W         32

// Byte addresses of the channel registers
`define ADDR_CTL_CH0_2     32'h0080_0238
`define ADDR_CTL_CH3_6     32'h0080_0239
`define ADDR_FLAGS_CH7_11  32'h0080_023A
`define ADDR_MASKS_CH7_11  32'h0080_023B
`define ADDR_FLAGS_CH12_19 32'h0080_023C
`define ADDR_MASKS_CH12_19 32'h0080_023D

// Byte addresses of the group event registers
`define ADDR_EVT_STATUS    32'h0080_0240
`define ADDR_EVT_CLEAR     32'h0080_0241
`define ADDR_EVT_ENABLE    32'h0080_0242

// Channel ranges of each group
`define CH_G0 2:0
`define CH_G1 6:3
`define CH_G2 11:7
`define CH_G3 19:12
`define G0_W  3
`define G1_W  4
`define G2_W  5
`define G3_W  8

// Field positions inside the data byte
`define R0_FLAG 6:4
`define R0_MASK 2:0
`define R1_FLAG 7:4
`define R1_MASK 3:0
`define R2_FLAG 4:0
`define R3_MASK 4:0
`define R4_FLAG 7:0
`define R5_MASK 7:0
`define EVT_FIELD 3:0

// Reset and constant values
`define CHAN_ZERO  20'h0_0000
`define GROUP_ZERO 4'h0
`define BYTE_ZERO  8'h00
`define BIT_ZERO   1'b0

`endif

// ---- shared/tirq_pkg.sv ----
`include "tirq_cfg.svh"

package tirq_pkg;
	typedef logic [`CHAN_CNT-1:0]  chan_vec_t;
	typedef logic [`GROUP_CNT-1:0] group_vec_t;
	typedef logic [`DATA_W-1:0]    data_byte_t;
	typedef logic [`ADDR_W-1:0]    bus_addr_t;
endpackage : tirq_pkg
